// ### rtl/csr_rx_port.sv
// Streaming receive credit port with transmit parity check and link activation
`timescale 1ns/1ps
module csr_rx_port (
    input wire logic clk,
    input wire logic rstn,
    input wire logic tx_valid,
    input wire logic [csr_pkg::DATA_W-1:0] tx_data,
    input wire logic [csr_pkg::TX_USER_W-1:0] tx_user,
    input wire logic parity_enable,
    output logic tx_nullify,
    output logic uncorrectable_error,
    output logic [3:0] tx_end_offset3,
    output logic [3:0] tx_end_offset4,
    input wire logic link_need,
    input wire logic in_valid,
    output logic in_ready,
    input wire csr_pkg::csr_beat_t in_beat,
    output logic [csr_pkg::DATA_W-1:0] rx_data,
    output logic [csr_pkg::USER_W-1:0] rx_user,
    output logic rx_valid,
    input wire logic credit_grant,
    output logic credit_return,
    output logic active_req,
    input wire logic active_ack,
    input wire logic deact_hint,
    output logic link_active
);
    csr_pkg::csr_link_t state;
    csr_pkg::csr_link_t next_state;
    logic [csr_pkg::CREDIT_W-1:0] credits;
    logic [csr_pkg::BYTES-1:0] byte_ok;
    logic [3:0] tx_flags;
    logic [3:0] head_flags;
    logic fifo_valid;
    logic fifo_ready;
    csr_pkg::csr_beat_t head;
    logic send;
    logic returning;

    // Per-byte odd parity: byte xor parity bit must be one
    genvar gi;
    generate
        for (gi = 0; gi < csr_pkg::BYTES; gi++)
        begin : g_par
            assign byte_ok[gi] = ^{tx_data[gi*8 +: 8], tx_user[csr_pkg::PARITY_LO + gi]};
        end
    endgenerate

    assign tx_flags = tx_user[csr_pkg::END_FLAGS_LO +: 4];

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            tx_nullify <= 1'b0;
            uncorrectable_error <= 1'b0;
        end
        else
        begin
            tx_nullify <= tx_valid && parity_enable && !(&byte_ok);
            uncorrectable_error <= tx_valid && parity_enable && !(&byte_ok);
        end
    end

    // Offsets forwarded only when their end flag bit is set
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            tx_end_offset3 <= 4'h0;
            tx_end_offset4 <= 4'h0;
        end
        else if (tx_valid)
        begin
            tx_end_offset3 <= tx_flags[2] ? tx_user[csr_pkg::THIRD_END_LO +: 4] : 4'h0;
            tx_end_offset4 <= tx_flags[3] ? tx_user[csr_pkg::FOURTH_END_LO +: 4] : 4'h0;
        end
    end

    // Link activation state machine
    always_comb
    begin
        next_state = state;
        case (state)
            csr_pkg::LINK_STOP:
                if (link_need && !deact_hint)
                begin
                    next_state = csr_pkg::LINK_REQ;
                end
            csr_pkg::LINK_REQ:
                if (deact_hint)
                begin
                    next_state = csr_pkg::LINK_DEACT;
                end
                else if (active_ack)
                begin
                    next_state = csr_pkg::LINK_ACTIVE;
                end
            csr_pkg::LINK_ACTIVE:
                if (deact_hint || !link_need)
                begin
                    next_state = csr_pkg::LINK_DEACT;
                end
            default:
                next_state = csr_pkg::LINK_STOP;
        endcase
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state <= csr_pkg::LINK_STOP;
            active_req <= 1'b0;
            link_active <= 1'b0;
        end
        else
        begin
            state <= next_state;
            active_req <= (next_state == csr_pkg::LINK_REQ) || (next_state == csr_pkg::LINK_ACTIVE);
            link_active <= (next_state == csr_pkg::LINK_ACTIVE);
        end
    end

    assign returning = (state == csr_pkg::LINK_DEACT);

    // Credit counter; a sent beat spends one credit per packet end, capped at the credits held
    assign head_flags = head.user[csr_pkg::RX_END_FLAGS_LO +: 4];
    assign send = fifo_valid && (state == csr_pkg::LINK_ACTIVE) && (credits != csr_pkg::CREDIT_RESET);
    assign fifo_ready = send;

    function automatic logic [csr_pkg::CREDIT_W-1:0] ends_in(input logic [3:0] f);
        logic [csr_pkg::CREDIT_W-1:0] n;
        n = 8'h00;
        case (f)
            csr_pkg::END_ONE: n = 8'h01;
            csr_pkg::END_TWO: n = 8'h02;
            csr_pkg::END_THREE: n = 8'h03;
            csr_pkg::END_FOUR: n = 8'h04;
            default: n = 8'h00;
        endcase
        return n;
    endfunction

    logic [csr_pkg::CREDIT_W-1:0] spend;
    assign spend = send ? ((ends_in(head_flags) > credits) ? credits : ends_in(head_flags)) : 8'h00;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            credits <= csr_pkg::CREDIT_RESET;
            credit_return <= 1'b0;
        end
        else if (returning)
        begin
            credits <= csr_pkg::CREDIT_RESET;
            credit_return <= (credits != csr_pkg::CREDIT_RESET);
        end
        else
        begin
            credit_return <= 1'b0;
            credits <= credits - spend + ((credit_grant && (credits != 8'hff)) ? 8'h01 : 8'h00);
        end
    end

    // Receive output stage
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rx_valid <= 1'b0;
            rx_data <= '0;
            rx_user <= '0;
        end
        else
        begin
            rx_valid <= send;
            if (send)
            begin
                rx_data <= head.data;
                rx_user <= head.user;
            end
        end
    end

    csr_fifo #(
        .WIDTH($bits(csr_pkg::csr_beat_t)),
        .DEPTH(csr_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rstn(rstn),
        .in_valid(in_valid),
        .in_ready(in_ready),
        .in_data(in_beat),
        .out_valid(fifo_valid),
        .out_ready(fifo_ready),
        .out_data(head),
        .flush(1'b0)
    );

    a_valid_needs_credit: assert property (@(posedge clk) disable iff (!rstn)
        rx_valid |-> $past(credits) != 8'h00)
        else $error("valid sent without credit");

    a_valid_follows_send: assert property (@(posedge clk) disable iff (!rstn)
        send |=> rx_valid)
        else $error("valid missing after send");

    a_parity_nullify: assert property (@(posedge clk) disable iff (!rstn)
        (tx_valid && parity_enable && !(&byte_ok)) |=> tx_nullify && uncorrectable_error)
        else $error("parity error not nullified");

    a_no_false_nullify: assert property (@(posedge clk) disable iff (!rstn)
        !parity_enable |=> !tx_nullify)
        else $error("nullify without parity check");

    a_hint_deact: assert property (@(posedge clk) disable iff (!rstn)
        (deact_hint && state == csr_pkg::LINK_ACTIVE) |=> state == csr_pkg::LINK_DEACT ##1 credits == 8'h00)
        else $error("hint did not deactivate");

    a_return_pulse: assert property (@(posedge clk) disable iff (!rstn)
        (returning && credits != 8'h00) |=> credit_return)
        else $error("credits not returned");

    a_req_held: assert property (@(posedge clk) disable iff (!rstn)
        (state == csr_pkg::LINK_ACTIVE && link_need && !deact_hint) |=> active_req)
        else $error("request dropped while active");

    a_grant_count: assert property (@(posedge clk) disable iff (!rstn)
        (credit_grant && !send && !returning && credits < 8'hff) |=> credits == $past(credits) + 8'h01)
        else $error("grant not counted");

    a_offset_gate: assert property (@(posedge clk) disable iff (!rstn)
        (tx_valid && !tx_flags[2]) |=> tx_end_offset3 == 4'h0)
        else $error("third offset without flag");
endmodule

// ### rtl/csr_pkg.sv
// Package for the streaming receive credit port: widths, field positions, encodings, carriers
package csr_pkg;
    localparam int DATA_W = 512;
    localparam int USER_W = 100;
    localparam int BYTES = 64;
    localparam int FIFO_DEPTH = 32;
    localparam int CREDIT_W = 8;
    localparam int TX_USER_W = 100;
    localparam int END_FLAGS_LO = 12;
    localparam int THIRD_END_LO = 28;
    localparam int FOURTH_END_LO = 32;
    localparam int PARITY_LO = 36;
    localparam int RX_END_FLAGS_LO = 12;
    localparam logic [3:0] END_NONE = 4'h0;
    localparam logic [3:0] END_ONE = 4'h1;
    localparam logic [3:0] END_TWO = 4'h3;
    localparam logic [3:0] END_THREE = 4'h7;
    localparam logic [3:0] END_FOUR = 4'hf;
    localparam logic [CREDIT_W-1:0] CREDIT_RESET = 8'h00;

    typedef struct packed {
        logic [USER_W-1:0] user;
        logic [DATA_W-1:0] data;
    } csr_beat_t;

    typedef enum logic [1:0] {
        LINK_STOP = 2'b00,
        LINK_REQ = 2'b01,
        LINK_ACTIVE = 2'b10,
        LINK_DEACT = 2'b11
    } csr_link_t;
endpackage

// ### rtl/csr_fifo.sv
// Parameterised flip-flop FIFO with valid and ready on both sides
`timescale 1ns/1ps
module csr_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    input wire logic flush
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic [AW:0] next_count;
    logic push;
    logic pop;

    // Ready is registered from the next fill level, so it leaves the block from a flip-flop
    assign next_count = count + (AW+1)'(push) - (AW+1)'(pop);
    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];
    assign push = in_valid && in_ready && !flush;
    assign pop = out_valid && out_ready && !flush;

    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            in_ready <= 1'b1;
        end
        else if (flush)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            in_ready <= 1'b1;
        end
        else
        begin
            if (push)
            begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop)
            begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= next_count;
            in_ready <= (next_count != (AW+1)'(DEPTH));
        end
    end
endmodule

// ### verification/csr_app_model.sv
// Application-side partner: activation acknowledge, credit grants, deactivation hint
`timescale 1ns/1ps
module csr_app_model (
    input wire logic clk,
    input wire logic rstn,
    input wire logic active_req,
    input wire logic grant_go,
    input wire logic [7:0] grant_cnt,
    input wire logic hint_cmd,
    output logic credit_grant,
    output logic active_ack,
    output logic deact_hint
);
    logic [7:0] left;
    logic [1:0] ack_wait;
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            left <= 8'h00;
        else if (grant_go)
            left <= grant_cnt;
        else if (left != 8'h00)
            left <= left - 8'h01;
    end
    // One grant pulse cycle per credit
    assign credit_grant = left != 8'h00;
    // Slow acknowledge, dropped with the request
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ack_wait <= 2'h0;
            active_ack <= 1'b0;
        end
        else if (!active_req)
        begin
            ack_wait <= 2'h0;
            active_ack <= 1'b0;
        end
        else if (ack_wait != 2'h3)
            ack_wait <= ack_wait + 2'h1;
        else
            active_ack <= 1'b1;
    end
    assign deact_hint = hint_cmd;
endmodule

// ### verification/csr_rx_port_bench.sv
// Self-checking bench for the receive credit port
`timescale 1ns/1ps
module csr_rx_port_bench;
    typedef struct packed {
        logic [3:0] flags;
        logic en;
        logic bad;
        logic [3:0] o3;
        logic [3:0] o4;
        logic nul;
    } csr_row_t;
    localparam csr_row_t ROWS [6] = '{'{4'h0, 1'b1, 1'b0, 4'h0, 4'h0, 1'b0}, '{4'h1, 1'b1, 1'b1, 4'h0, 4'h0, 1'b1},
        '{4'h3, 1'b0, 1'b1, 4'h0, 4'h0, 1'b0}, '{4'h7, 1'b1, 1'b0, 4'ha, 4'h0, 1'b0},
        '{4'hf, 1'b1, 1'b1, 4'ha, 4'h5, 1'b1}, '{4'hf, 1'b0, 1'b0, 4'ha, 4'h5, 1'b0}};
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic tx_valid = 1'b0;
    logic [csr_pkg::DATA_W-1:0] tx_data = {8{64'h0f1e2d3c4b5a6978}};
    logic [csr_pkg::TX_USER_W-1:0] tx_user = '0;
    logic parity_enable = 1'b0;
    logic link_need = 1'b0;
    logic in_valid = 1'b0;
    csr_pkg::csr_beat_t in_beat = '0;
    logic grant_go = 1'b0;
    logic [7:0] grant_cnt = 8'h00;
    logic hint_cmd = 1'b0;
    logic tx_nullify, uncorrectable_error, in_ready, rx_valid, credit_return, active_req, active_ack;
    logic deact_hint, link_active, credit_grant;
    logic [3:0] tx_end_offset3, tx_end_offset4;
    logic [csr_pkg::DATA_W-1:0] rx_data;
    logic [csr_pkg::USER_W-1:0] rx_user;
    logic [63:0] par;
    int n_fail = 0;
    int total_checks = 0;
    int n_ret = 0;
    int i;
    csr_pkg::csr_beat_t exp_q[$];
    csr_pkg::csr_beat_t got_q[$];
    always #20 clk = ~clk;
    csr_rx_port csr_rx_port_i (.clk(clk), .rstn(rstn), .tx_valid(tx_valid), .tx_data(tx_data), .tx_user(tx_user),
        .parity_enable(parity_enable), .tx_nullify(tx_nullify), .uncorrectable_error(uncorrectable_error),
        .tx_end_offset3(tx_end_offset3), .tx_end_offset4(tx_end_offset4), .link_need(link_need),
        .in_valid(in_valid), .in_ready(in_ready), .in_beat(in_beat), .rx_data(rx_data), .rx_user(rx_user),
        .rx_valid(rx_valid), .credit_grant(credit_grant), .credit_return(credit_return),
        .active_req(active_req), .active_ack(active_ack), .deact_hint(deact_hint), .link_active(link_active));
    csr_app_model csr_app_model_i (.clk(clk), .rstn(rstn), .active_req(active_req), .grant_go(grant_go),
        .grant_cnt(grant_cnt), .hint_cmd(hint_cmd), .credit_grant(credit_grant), .active_ack(active_ack),
        .deact_hint(deact_hint));
    always @(posedge clk)
    begin
        if (rx_valid === 1'b1)
            got_q.push_back({rx_user, rx_data});
        if (credit_return === 1'b1)
            n_ret++;
    end
    task automatic chk_val(input string what, input logic [611:0] exp, input logic [611:0] got);
        total_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_flag(input string what, input logic exp, input logic got);
        chk_val(what, {611'h0, exp}, {611'h0, got});
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic push(input logic [3:0] f, input logic [31:0] k);
        int j;
        @(negedge clk);
        in_beat = {84'h0, f, 12'h000, {16{k}}};
        in_valid = 1'b1;
        exp_q.push_back(in_beat);
        for (j = 0; j < 20 && in_ready !== 1'b1; j++)
            @(negedge clk);
        chk_flag("in_ready", 1'b1, in_ready);
        if (in_ready !== 1'b1)
            final_report();
        @(negedge clk);
        in_valid = 1'b0;
    endtask
    task automatic grant(input logic [7:0] n);
        @(negedge clk);
        grant_cnt = n;
        grant_go = 1'b1;
        @(negedge clk);
        grant_go = 1'b0;
        repeat (n + 8'h04) @(negedge clk);
    endtask
    task automatic wait_lvl(input string what, input int sel, input logic lvl);
        int j;
        for (j = 0; j < 30 && (sel == 0 ? active_req : link_active) !== lvl; j++)
            @(negedge clk);
        chk_flag(what, lvl, sel == 0 ? active_req : link_active);
        if ((sel == 0 ? active_req : link_active) !== lvl)
            final_report();
    endtask
    initial
    begin
        repeat (20) @(negedge clk);
        chk_flag("reset active_req", 1'b0, active_req);
        chk_flag("reset rx_valid", 1'b0, rx_valid);
        rstn = 1'b1;
        for (i = 0; i < 6; i++)
        begin
            for (int b = 0; b < 64; b++)
                par[b] = ~^tx_data[8*b+:8];
            par = ROWS[i].bad ? par ^ 64'h0000000000000001 : par;
            @(negedge clk);
            tx_user = {par, 4'h5, 4'ha, 12'h000, ROWS[i].flags, 12'h000};
            parity_enable = ROWS[i].en;
            tx_valid = 1'b1;
            @(negedge clk);
            tx_valid = 1'b0;
            chk_val("offset3", {608'h0, ROWS[i].o3}, {608'h0, tx_end_offset3});
            chk_val("offset4", {608'h0, ROWS[i].o4}, {608'h0, tx_end_offset4});
            chk_flag("nullify", ROWS[i].nul, tx_nullify);
            chk_flag("uncorrectable", ROWS[i].nul, uncorrectable_error);
            @(negedge clk);
            chk_flag("nullify end", 1'b0, tx_nullify);
        end
        link_need = 1'b1;
        wait_lvl("active_req up", 0, 1'b1);
        wait_lvl("link_active up", 1, 1'b1);
        grant(8'h03);
        push(csr_pkg::END_TWO, 32'h00000001);
        push(csr_pkg::END_ONE, 32'h00000002);
        push(csr_pkg::END_ONE, 32'h00000003);
        repeat (10) @(negedge clk);
        chk_val("rx count no credit", 612'h2, 612'(got_q.size()));
        grant(8'h01);
        chk_val("rx count credit", 612'h3, 612'(got_q.size()));
        grant(8'h02);
        hint_cmd = 1'b1;
        wait_lvl("active_req down", 0, 1'b0);
        chk_flag("link_active down", 1'b0, link_active);
        repeat (5) @(negedge clk);
        chk_val("return pulses", 612'h1, 612'(n_ret));
        hint_cmd = 1'b0;
        wait_lvl("re-request", 0, 1'b1);
        link_need = 1'b0;
        wait_lvl("request dropped", 0, 1'b0);
        repeat (5) @(negedge clk);
        for (i = 0; i < csr_pkg::FIFO_DEPTH; i++)
            push(csr_pkg::END_ONE, 32'(i + 16));
        @(negedge clk);
        in_valid = 1'b1;
        @(negedge clk);
        chk_flag("in_ready full", 1'b0, in_ready);
        in_valid = 1'b0;
        link_need = 1'b1;
        wait_lvl("link_active again", 1, 1'b1);
        grant(8'h20);
        repeat (10) @(negedge clk);
        chk_val("rx count", 612'(exp_q.size()), 612'(got_q.size()));
        for (i = 0; i < exp_q.size() && i < got_q.size(); i++)
            chk_val("rx beat", exp_q[i], got_q[i]);
        final_report();
    end
endmodule
